// ---- pm_cap_pkg.sv ----
// Constants for the power management capability register pair.
// Assumes a 40 MHz core clock and a plain strobe-based register port.
//
// Contract
// - capability id byte always reads 0x1
// - next pointer defaults 0xD0, loader-writable only
// - version field reads constant 3
// - wake clock flag hardwired to zero
// - special init flag defaults zero, loader-writable
// - sticky aux current field defaults to 7
// - D1 and D2 support bits read zero
// - sticky wake support field defaults 0b11001
// - power state field readable and writable
// - context kept flag defaults to one
// - sticky wake enable, survives hot reset
// - wake status set on own wake, W1C
// - forwarded wake never sets wake status
// - upstream port never sets wake status
// - data select, scale, data byte read zero
// - bus power bits 22, 23 read zero
package pm_cap_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	// register byte offsets
	localparam logic [11:0] PM_CAPABILITIES_OFS   = 12'h0C0;
	localparam logic [11:0] PM_CONTROL_STATUS_OFS = 12'h0C4;
	localparam logic [11:0] IRQ_STATUS_OFS        = 12'h100;
	localparam logic [11:0] IRQ_MASK_OFS          = 12'h104;
	// capability word fields
	localparam int CAP_ID_LSB       = 0;
	localparam int NEXT_PTR_LSB     = 8;
	localparam int SPEC_REV_LSB     = 16;
	localparam int WAKE_CLK_BIT     = 19;
	localparam int SPECIAL_INIT_BIT = 21;
	localparam int AUX_CUR_LSB      = 22;
	localparam int D1_BIT           = 25;
	localparam int D2_BIT           = 26;
	localparam int WAKE_SUP_LSB     = 27;
	// control/status word fields
	localparam int POWER_STATE_FIELD_LSB       = 0;
	localparam int CONTEXT_KEPT_BIT = 3;
	localparam int WAKE_EN_BIT      = 8;
	localparam int WAKE_STS_BIT     = 15;
	// fields that always read zero
	localparam int CAP_RSVD_BIT     = 20;
	localparam int DATA_SEL_LSB     = 9;
	localparam int DATA_SCALE_LSB   = 13;
	localparam int BUS_PWR_SUP_BIT  = 22;
	localparam int BUS_PWR_CTL_BIT  = 23;
	localparam int DATA_BYTE_LSB    = 24;
	// fixed values and reset values
	localparam logic [7:0] CAP_ID_VAL        = 8'h01;
	localparam logic [7:0] NEXT_PTR_RST      = 8'hD0;
	localparam logic [2:0] SPEC_REV_VAL      = 3'h3;
	localparam logic       SPECIAL_INIT_RST  = 1'h0;
	localparam logic [2:0] AUX_CUR_RST       = 3'h7;
	localparam logic [4:0] WAKE_SUP_RST      = 5'h19;
	localparam logic       CONTEXT_KEPT_RST  = 1'h1;
	localparam logic       WAKE_EN_RST       = 1'h0;
	// power state codes
	localparam logic [1:0] POWER_STATE_FIELD_D0    = 2'h0;
	localparam logic [1:0] POWER_STATE_FIELD_D3HOT = 2'h3;
	// interrupt status/mask layout
	localparam int IRQ_W           = 3;
	localparam int IRQ_WAKE_BIT    = 0;
	localparam int IRQ_POWER_STATE_FIELD_BIT  = 1;
	localparam int IRQ_REFUSED_BIT = 2;
	localparam logic [2:0] IRQ_MASK_RST = 3'h0;
endpackage

// ---- power_mgmt_capability_regs.sv ----
// Power management capability pair of one switch port, with an
// interrupt status/mask pair for its events.
// Assumes one 40 MHz clock, synchronous rst (fundamental reset) and
// hot_reset, and a register port with read data one cycle after strobe.
// Sticky fields and the interrupt pair answer to rst alone.
`timescale 1ns/1ps
module power_mgmt_capability_regs (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        hot_reset,
	// software register port
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// initialization loader write port
	input  wire logic [11:0] load_addr,
	input  wire logic [31:0] load_wdata,
	input  wire logic        load_wr,
	// port role and wake events
	input  wire logic        upstream_port,
	input  wire logic        wake_originate,
	input  wire logic        wake_forward,
	output logic             wake_msg_send,
	output logic [1:0]       power_state,
	output logic             context_kept,
	output logic             irq
);
	// interrupt pair width, declared ahead of the vectors that use it
	localparam int IRQ_W_L = pm_cap_pkg::IRQ_W;

	// write decode
	logic        sw_cap_wr;
	logic        sw_ctl_wr;
	logic        sw_sts_wr;
	logic        sw_mask_wr;
	logic        ld_cap_wr;
	logic        ld_ctl_wr;

	// loadable capability fields
	logic [7:0]  next_cap_pointer_reg;
	logic        special_init_needed_reg;
	// sticky capability fields
	logic [2:0]  aux_current_req_reg;
	logic [4:0]  wake_support_reg;

	// control/status fields
	logic [1:0]  power_state_field;
	logic        context_kept_flag_reg;
	logic        wake_msg_enable_reg;
	logic        wake_msg_status;
	logic        wake_sts_set;
	logic        wake_sts_clr;
	logic        power_state_field_refused;
	logic        power_state_field_changed;

	// interrupt pair
	logic [IRQ_W_L-1:0] irq_status;
	logic [IRQ_W_L-1:0] irq_events;
	logic [IRQ_W_L-1:0] irq_mask_reg;

	// read path
	logic [31:0] cap_word;
	logic [31:0] ctl_word;
	logic [31:0] rd_word;
	logic [31:0] reg_rdata_next;

	// ----------------------------------------------------------------
	// address decode for both write ports
	// ----------------------------------------------------------------

	// software strobes qualified by address
	assign sw_cap_wr  = reg_wr &&
	                    (reg_addr == pm_cap_pkg::PM_CAPABILITIES_OFS);
	assign sw_ctl_wr  = reg_wr &&
	                    (reg_addr == pm_cap_pkg::PM_CONTROL_STATUS_OFS);
	assign sw_sts_wr  = reg_wr &&
	                    (reg_addr == pm_cap_pkg::IRQ_STATUS_OFS);
	assign sw_mask_wr = reg_wr &&
	                    (reg_addr == pm_cap_pkg::IRQ_MASK_OFS);

	// loader strobes; the loader reaches the same two words
	assign ld_cap_wr = load_wr &&
	                   (load_addr == pm_cap_pkg::PM_CAPABILITIES_OFS);
	assign ld_ctl_wr = load_wr &&
	                   (load_addr == pm_cap_pkg::PM_CONTROL_STATUS_OFS);

	// ----------------------------------------------------------------
	// capability word: loadable fields
	// ----------------------------------------------------------------

	// software writes to the capability word never reach the loadable
	// fields below; only the loader strobe is decoded for them
	// next pointer: only the loader may change it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			next_cap_pointer_reg <= pm_cap_pkg::NEXT_PTR_RST;
		end else if (ld_cap_wr) begin
			next_cap_pointer_reg <=
			    load_wdata[pm_cap_pkg::NEXT_PTR_LSB +: 8];
		end
	end

	// special init flag: zero out of reset, loader may set it
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			special_init_needed_reg <=
			    pm_cap_pkg::SPECIAL_INIT_RST;
		end else if (ld_cap_wr) begin
			special_init_needed_reg <=
			    load_wdata[pm_cap_pkg::SPECIAL_INIT_BIT];
		end
	end

	// ----------------------------------------------------------------
	// capability word: sticky fields
	// ----------------------------------------------------------------

	// aux current: only rst restores it, hot reset leaves it alone
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			aux_current_req_reg <= pm_cap_pkg::AUX_CUR_RST;
		end else if (ld_cap_wr) begin
			aux_current_req_reg <=
			    load_wdata[pm_cap_pkg::AUX_CUR_LSB +: 3];
		end else if (sw_cap_wr) begin
			aux_current_req_reg <=
			    reg_wdata[pm_cap_pkg::AUX_CUR_LSB +: 3];
		end
	end

	// wake support states: sticky, software or loader writable
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wake_support_reg <= pm_cap_pkg::WAKE_SUP_RST;
		end else if (ld_cap_wr) begin
			wake_support_reg <=
			    load_wdata[pm_cap_pkg::WAKE_SUP_LSB +: 5];
		end else if (sw_cap_wr) begin
			wake_support_reg <=
			    reg_wdata[pm_cap_pkg::WAKE_SUP_LSB +: 5];
		end
	end

	// ----------------------------------------------------------------
	// control/status word
	// ----------------------------------------------------------------

	// power state holder; refuses codes 1 and 2
	power_state_ctl power_state_ctl_i (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.hot_reset (hot_reset),
		.wr_en     (sw_ctl_wr),
		.wr_code   (reg_wdata[pm_cap_pkg::POWER_STATE_FIELD_LSB +: 2]),
		.state_reg (power_state_field),
		.refused   (power_state_field_refused),
		.changed   (power_state_field_changed)
	);

	// context kept flag: loader-writable, set out of reset
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			context_kept_flag_reg <=
			    pm_cap_pkg::CONTEXT_KEPT_RST;
		end else if (ld_ctl_wr) begin
			context_kept_flag_reg <=
			    load_wdata[pm_cap_pkg::CONTEXT_KEPT_BIT];
		end
	end

	// wake enable: sticky, so hot_reset is deliberately not used here;
	// the loader can preset it for wake from D3cold
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wake_msg_enable_reg <= pm_cap_pkg::WAKE_EN_RST;
		end else if (ld_ctl_wr) begin
			wake_msg_enable_reg <=
			    load_wdata[pm_cap_pkg::WAKE_EN_BIT];
		end else if (sw_ctl_wr) begin
			wake_msg_enable_reg <=
			    reg_wdata[pm_cap_pkg::WAKE_EN_BIT];
		end
	end

	// wake status sets on this port's own wake only, never upstream;
	// a forwarded wake does not enter this term at all: wake_forward is
	// left unread on purpose, since passing a wake along must leave the
	// status and the interrupt untouched and happens outside this block
	assign wake_sts_set = wake_originate && !upstream_port;
	assign wake_sts_clr = sw_ctl_wr &&
	                      reg_wdata[pm_cap_pkg::WAKE_STS_BIT];

	// sticky flag cell; only rst clears it besides software
	sticky_w1c_bit sticky_w1c_bit_i (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.set_evt  (wake_sts_set),
		.clr_evt  (wake_sts_clr),
		.flag_reg (wake_msg_status)
	);

	// a wake goes out only when enabled and originated by this port
	assign wake_msg_send = wake_originate && wake_msg_enable_reg &&
	                       !upstream_port;

	// ----------------------------------------------------------------
	// interrupt status and mask
	// ----------------------------------------------------------------

	// events feeding the sticky status bits
	always_comb begin
		irq_events = '0;
		irq_events[pm_cap_pkg::IRQ_WAKE_BIT]    = wake_sts_set;
		irq_events[pm_cap_pkg::IRQ_POWER_STATE_FIELD_BIT]  = power_state_field_changed;
		irq_events[pm_cap_pkg::IRQ_REFUSED_BIT] = power_state_field_refused;
	end

	// one write-one-to-clear cell per status bit
	genvar gi;
	generate
		for (gi = 0; gi < IRQ_W_L; gi = gi + 1) begin : g_irq
			sticky_w1c_bit sticky_w1c_bit_i (
				.ref_clk  (ref_clk),
				.rst      (rst),
				.set_evt  (irq_events[gi]),
				.clr_evt  (sw_sts_wr && reg_wdata[gi]),
				.flag_reg (irq_status[gi])
			);
		end
	endgenerate

	// mask register, one enable per status bit
	// a set mask bit lets its status bit through to irq
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_mask_reg <= pm_cap_pkg::IRQ_MASK_RST;
		end else if (sw_mask_wr) begin
			irq_mask_reg <= reg_wdata[IRQ_W_L-1:0];
		end
	end

	// level interrupt while any unmasked status bit stands
	assign irq = |(irq_status & irq_mask_reg);

	// ----------------------------------------------------------------
	// read composition
	// ----------------------------------------------------------------

	// capability word; unlisted bits, bit 20 among them, stay zero
	always_comb begin
		cap_word = '0;
		cap_word[pm_cap_pkg::CAP_ID_LSB +: 8] =
		    pm_cap_pkg::CAP_ID_VAL;
		cap_word[pm_cap_pkg::NEXT_PTR_LSB +: 8] =
		    next_cap_pointer_reg;
		cap_word[pm_cap_pkg::SPEC_REV_LSB +: 3] =
		    pm_cap_pkg::SPEC_REV_VAL;
		cap_word[pm_cap_pkg::WAKE_CLK_BIT] = 1'h0;
		cap_word[pm_cap_pkg::CAP_RSVD_BIT] = 1'h0;
		cap_word[pm_cap_pkg::SPECIAL_INIT_BIT] =
		    special_init_needed_reg;
		cap_word[pm_cap_pkg::AUX_CUR_LSB +: 3] =
		    aux_current_req_reg;
		cap_word[pm_cap_pkg::D1_BIT] = 1'h0;
		cap_word[pm_cap_pkg::D2_BIT] = 1'h0;
		cap_word[pm_cap_pkg::WAKE_SUP_LSB +: 5] =
		    wake_support_reg;
	end

	// control word; data select, scale, bus power bits and the data
	// byte are left at zero along with the reserved positions
	always_comb begin
		ctl_word = '0;
		// absent data register fields and the bus power bits
		ctl_word[pm_cap_pkg::DATA_SEL_LSB +: 4]   = 4'h0;
		ctl_word[pm_cap_pkg::DATA_SCALE_LSB +: 2] = 2'h0;
		ctl_word[pm_cap_pkg::DATA_BYTE_LSB +: 8]  = 8'h0;
		ctl_word[pm_cap_pkg::BUS_PWR_SUP_BIT]     = 1'h0;
		ctl_word[pm_cap_pkg::BUS_PWR_CTL_BIT]     = 1'h0;
		ctl_word[pm_cap_pkg::POWER_STATE_FIELD_LSB +: 2] =
		    power_state_field;
		ctl_word[pm_cap_pkg::CONTEXT_KEPT_BIT] =
		    context_kept_flag_reg;
		ctl_word[pm_cap_pkg::WAKE_EN_BIT] =
		    wake_msg_enable_reg;
		ctl_word[pm_cap_pkg::WAKE_STS_BIT] =
		    wake_msg_status;
	end

	// address select; unmapped addresses read zero
	always_comb begin
		rd_word = '0;
		unique case (reg_addr)
			pm_cap_pkg::PM_CAPABILITIES_OFS: begin
				rd_word = cap_word;
			end
			pm_cap_pkg::PM_CONTROL_STATUS_OFS: begin
				rd_word = ctl_word;
			end
			pm_cap_pkg::IRQ_STATUS_OFS: begin
				rd_word[IRQ_W_L-1:0] = irq_status;
			end
			pm_cap_pkg::IRQ_MASK_OFS: begin
				rd_word[IRQ_W_L-1:0] = irq_mask_reg;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	// read data stands only in the cycle after the strobe
	// and is zero otherwise, so a stray sample never shows stale data
	assign reg_rdata_next = reg_rd ? rd_word : '0;

	// registered read data
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= reg_rdata_next;
		end
	end

	// ----------------------------------------------------------------
	// status outputs to the port logic
	// ----------------------------------------------------------------

	// registered copy of the power state for the port's power sequencing logic; the
	// output trails the field by one cycle, so a new state is seen by
	// the sequencer only after the write has fully landed
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			power_state <= pm_cap_pkg::POWER_STATE_FIELD_D0;
		end else begin
			power_state <= power_state_field;
		end
	end

	// context flag tells the sequencer whether to keep state on D0 entry
	assign context_kept = context_kept_flag_reg;
endmodule

// ---- power_mgmt_capability_regs_asserts.sv ----
// Checker for the power management register pair, ports only.
// Assumes one ref_clk domain and synchronous active-high rst.
`timescale 1ns/1ps
module pm_regs_checker (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        hot_reset,
	input wire logic [11:0] reg_addr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        upstream_port,
	input wire logic        wake_originate,
	input wire logic        wake_msg_send,
	input wire logic [1:0]  power_state,
	input wire logic        context_kept
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic cap_rd_reg;
	logic ctl_rd_reg;
	logic unm_rd_reg;
	// remember which word the last read strobe addressed
	always_ff @(posedge ref_clk) begin
		cap_rd_reg <= reg_rd && reg_addr == 12'h0C0;
		ctl_rd_reg <= reg_rd && reg_addr == 12'h0C4;
		unm_rd_reg <= reg_rd && !(reg_addr inside
			{12'h0C0, 12'h0C4, 12'h100, 12'h104});
	end
	a_rdata_idle_zero: assert property (
		!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside a read");
	a_cap_fixed_bits: assert property (
		cap_rd_reg |-> reg_rdata[7:0] == 8'h01 &&
		reg_rdata[20:16] == 5'h03 && reg_rdata[26:25] == 2'h0)
		else $error("capability fixed bits wrong");
	a_ctl_zero_bits: assert property (
		ctl_rd_reg |-> reg_rdata[31:16] == 16'h0 &&
		reg_rdata[14:9] == 6'h0 && reg_rdata[7:4] == 4'h0 &&
		reg_rdata[2] == 1'b0)
		else $error("control word zero bits set");
	a_power_state_field_legal: assert property (
		ctl_rd_reg |-> reg_rdata[1:0] inside {2'h0, 2'h3})
		else $error("unsupported power state held");
	a_power_state_field_output: assert property (
		ctl_rd_reg |-> reg_rdata[1:0] == power_state)
		else $error("power state output disagrees with field");
	a_ctx_output: assert property (
		ctl_rd_reg |-> reg_rdata[3] == context_kept)
		else $error("context kept output disagrees with field");
	a_wake_cause: assert property (
		wake_msg_send |-> wake_originate && !upstream_port)
		else $error("wake message without own wake");
	a_hot_to_d0: assert property (
		hot_reset |-> ##2 power_state == 2'h0)
		else $error("hot reset did not return to D0");
	a_unmapped_zero: assert property (
		unm_rd_reg |-> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
endmodule
bind power_mgmt_capability_regs pm_regs_checker pm_regs_checker_i (
	.ref_clk(ref_clk), .rst(rst), .hot_reset(hot_reset),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.upstream_port(upstream_port), .wake_originate(wake_originate),
	.wake_msg_send(wake_msg_send), .power_state(power_state),
	.context_kept(context_kept));

// ---- power_mgmt_capability_regs_tb.sv ----
// Self-checking bench for the power management register pair.
// Assumes read data one cycle after the read strobe.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module power_mgmt_capability_regs_tb;
	logic        ref_clk = 0;
	logic        rst = 1;
	logic        hot_reset = 0;
	logic [11:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0;
	logic        reg_wr = 0;
	logic        reg_rd = 0;
	logic [31:0] reg_rdata;
	logic [11:0] load_addr = 0;
	logic [31:0] load_wdata = 0;
	logic        load_wr = 0;
	logic        upstream_port = 0;
	logic        wake_originate = 0;
	logic        wake_forward = 0;
	logic        wake_msg_send;
	logic [1:0]  power_state;
	logic        context_kept;
	logic        irq;
	int          error_cnt = 0;
	int          n_checks = 0;
	power_mgmt_capability_regs power_mgmt_capability_regs_i (
		.ref_clk(ref_clk), .rst(rst), .hot_reset(hot_reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .load_addr(load_addr),
		.load_wdata(load_wdata), .load_wr(load_wr),
		.upstream_port(upstream_port), .wake_originate(wake_originate),
		.wake_forward(wake_forward), .wake_msg_send(wake_msg_send),
		.power_state(power_state), .context_kept(context_kept), .irq(irq));
	// 40 MHz clock
	initial begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask
	task automatic ld(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		load_addr  <= a;
		load_wdata <= d;
		load_wr    <= 1'b1;
		@(posedge ref_clk);
		load_wr <= 1'b0;
	endtask
	// one-cycle wake event; send is checked inside its cycle
	task automatic wk(input logic o, input logic f, input logic s);
		@(posedge ref_clk);
		wake_originate <= o;
		wake_forward   <= f;
		#1;
		`CHK(wake_msg_send, s)
		@(posedge ref_clk);
		wake_originate <= 1'b0;
		wake_forward   <= 1'b0;
	endtask
	// hang guard
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		report_and_stop();
	end
	// main sequence
	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		rc(12'h0C0, 32'hC9C3D001);
		rc(12'h0C4, 32'h00000008);
		`CHK(context_kept, 1'b1)
		`CHK(power_state, 2'h0)
		rc(12'h100, 32'h0);
		rc(12'h104, 32'h0);
		wr(12'h0C8, 32'hFFFFFFFF);
		rc(12'h0C8, 32'h0);
		// software reaches only the sticky capability fields
		wr(12'h0C0, 32'h003FFFFF);
		rc(12'h0C0, 32'h0003D001);
		@(posedge ref_clk);
		hot_reset <= 1'b1;
		@(posedge ref_clk);
		hot_reset <= 1'b0;
		rc(12'h0C0, 32'h0003D001);
		ld(12'h0C0, 32'hC9E3AB01);
		rc(12'h0C0, 32'hC9E3AB01);
		// power state writes, refused codes, interrupts
		wr(12'h104, 32'h7);
		wr(12'h0C4, 32'hFFFFFFFF);
		rc(12'h0C4, 32'h0000010B);
		`CHK(power_state, 2'h3)
		for (int c = 1; c < 3; c++) begin
			wr(12'h0C4, 32'h100 | c);
			rc(12'h0C4, 32'h0000010B);
		end
		rc(12'h100, 32'h6);
		`CHK(irq, 1'b1)
		wr(12'h100, 32'h6);
		rc(12'h100, 32'h0);
		`CHK(irq, 1'b0)
		// forwarded, upstream and own wake events
		wk(1'b0, 1'b1, 1'b0);
		rc(12'h0C4, 32'h0000010B);
		@(posedge ref_clk);
		upstream_port <= 1'b1;
		wk(1'b1, 1'b0, 1'b0);
		rc(12'h0C4, 32'h0000010B);
		@(posedge ref_clk);
		upstream_port <= 1'b0;
		wk(1'b1, 1'b0, 1'b1);
		rc(12'h0C4, 32'h0000810B);
		rc(12'h100, 32'h1);
		`CHK(irq, 1'b1)
		wr(12'h104, 32'h6);
		`CHK(irq, 1'b0)
		wr(12'h0C4, 32'h00008003);
		rc(12'h0C4, 32'h0000000B);
		wk(1'b1, 1'b0, 1'b0);
		rc(12'h0C4, 32'h0000800B);
		// own wake meets a clear in one cycle: the set wins
		@(posedge ref_clk);
		reg_addr       <= 12'h0C4;
		reg_wdata      <= 32'h00008003;
		reg_wr         <= 1'b1;
		wake_originate <= 1'b1;
		@(posedge ref_clk);
		reg_wr         <= 1'b0;
		wake_originate <= 1'b0;
		rc(12'h0C4, 32'h0000800B);
		// loader sets wake enable and clears context kept
		ld(12'h0C4, 32'h00000100);
		rc(12'h0C4, 32'h00008103);
		`CHK(context_kept, 1'b0)
		// hot reset keeps sticky fields, full reset clears them
		@(posedge ref_clk);
		hot_reset <= 1'b1;
		@(posedge ref_clk);
		hot_reset <= 1'b0;
		rc(12'h0C4, 32'h00008100);
		`CHK(power_state, 2'h0)
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		rc(12'h0C4, 32'h00000008);
		rc(12'h0C0, 32'hC9C3D001);
		report_and_stop();
	end
endmodule

// ---- power_state_ctl.sv ----
// Holds the power state field and screens writes to it.
// Assumes wr_en is a one-cycle strobe; hot_reset and rst are synchronous.
`timescale 1ns/1ps
module power_state_ctl (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       hot_reset,
	input  wire logic       wr_en,
	input  wire logic [1:0] wr_code,
	output logic [1:0]      state_reg,
	output logic            refused,
	output logic            changed
);
	logic code_ok;

	// only D0 and D3hot are accepted
	assign code_ok = (wr_code == pm_cap_pkg::POWER_STATE_FIELD_D0) ||
	                 (wr_code == pm_cap_pkg::POWER_STATE_FIELD_D3HOT);
	assign refused = wr_en && !code_ok;
	assign changed = wr_en && code_ok && (wr_code != state_reg);

	// state is not sticky: both resets return it to D0
	always_ff @(posedge ref_clk) begin
		if (rst || hot_reset) begin
			state_reg <= pm_cap_pkg::POWER_STATE_FIELD_D0;
		end else if (wr_en && code_ok) begin
			state_reg <= wr_code;
		end
	end
endmodule

// ---- sticky_w1c_bit.sv ----
// One status flag: set by a hardware event, cleared by a software write.
// Assumes set and clear are one-cycle pulses in the ref_clk domain.
`timescale 1ns/1ps
module sticky_w1c_bit (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic set_evt,
	input  wire logic clr_evt,
	output logic      flag_reg
);
	// set wins when it meets a clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			flag_reg <= 1'h0;
		end else if (set_evt) begin
			flag_reg <= 1'h1;
		end else if (clr_evt) begin
			flag_reg <= 1'h0;
		end
	end
endmodule
